//--- hdl/mmtc_pkg.sv
// ==========================================================================
// Package for the multi-mode timer/counter group.
// Holds divider figures, mode encodings, control structs and constants.
// Assumes a single 100 MHz clock and synchronous pin inputs.
package mmtc_pkg;

  // ========================================================================
  // Timing.
  // One machine cycle is two clocks; the peripheral clock runs at that rate.
  localparam logic       MC_LAST    = 1'b1;
  localparam logic       MC_FIRST   = 1'b0;

  // ========================================================================
  // Counts and widths.
  localparam int         N_LT       = 2;
  localparam int         N_ET       = 3;
  localparam int         N_PIN      = 5;
  localparam int         N_FALL     = 8;
  localparam int         ET_BASE    = 2;
  localparam logic [4:0] PRE_MAX    = 5'h1F;
  localparam logic [4:0] PRE_ZERO   = 5'h00;
  localparam logic [7:0] BYTE_MAX   = 8'hFF;
  localparam logic [7:0] BYTE_ONE   = 8'h01;
  localparam logic [15:0] WORD_MAX  = 16'hFFFF;
  localparam logic [15:0] WORD_ONE  = 16'h0001;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic       PIN_IDLE   = 1'b1;

  // ========================================================================
  // Modes of timers 0 and 1, in the order 0, 1, 2, 3, 6.
  typedef enum logic [2:0] {
    MMTC_LT_M13, MMTC_LT_M16, MMTC_LT_M8AR, MMTC_LT_SPLIT, MMTC_LT_PWM
  } mmtc_lt_mode_t;

  // Modes of timers 2, 3 and 4, in the order 0, 1, 2.
  typedef enum logic [1:0] {
    MMTC_ET_RELOAD, MMTC_ET_CAPTURE, MMTC_ET_PWM
  } mmtc_et_mode_t;

  // ========================================================================
  // Control groups.
  typedef struct packed {
    logic          run;
    logic          cnt_sel;
    logic          tog_en;
    mmtc_lt_mode_t mode;
  } mmtc_lt_ctl_t;

  typedef struct packed {
    logic          run;
    logic          cnt_sel;
    logic          tog_en;
    logic          trig_en;
    mmtc_et_mode_t mode;
  } mmtc_et_ctl_t;

endpackage

//--- hdl/mmtc_fall_det.sv
// ==========================================================================
// Falling-edge detector for a group of pins, sampled once per tick.
// Assumes the pins are already synchronous to clk.
`timescale 1ns/1ns

module mmtc_fall_det #(
  parameter int W = 1
) (
  input  logic         clk,
  input  logic         resetn,
  input  logic         sample_en,
  input  logic [W-1:0] pin,
  output logic [W-1:0] fall_r
);

  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;
  logic [W-1:0] fall_nxt;

  // ========================================================================
  // Sampling.
  // falling edge detect
  // The previous sample starts high, so a pin held low at reset gives a fall at the first sample.
  always_comb begin
    prev_nxt = sample_en ? pin : prev_r;
    fall_nxt = sample_en ? (prev_r & ~pin) : '0;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev_r <= '1;
      fall_r <= '0;
    end else begin
      prev_r <= prev_nxt;
      fall_r <= fall_nxt;
    end
  end

endmodule

//--- hdl/mmtc_ext_timer.sv
// ==========================================================================
// One 16-bit timer with reload, capture and PWM modes and a trigger input.
// Assumes tick and edge pulses from the parent, each one clock wide.
`timescale 1ns/1ns

module mmtc_ext_timer (
  input  logic                  clk,
  input  logic                  resetn,
  input  mmtc_pkg::mmtc_et_ctl_t ctl,
  input  logic                  pclk_tick,
  input  logic                  cnt_fall,
  input  logic                  trig_fall,
  input  logic                  load,
  input  logic [15:0]           load_val,
  input  logic [15:0]           reload,
  input  logic [15:0]           duty,
  output logic [15:0]           count_r,
  output logic [15:0]           capture_r,
  output logic                  ovf_r,
  output logic                  pin_r
);

  logic        phase_r;
  logic        phase_nxt;
  logic [15:0] count_nxt;
  logic [15:0] capture_nxt;
  logic        ovf_nxt;
  logic        pin_nxt;
  logic        tick;
  logic        trig;

  // ========================================================================
  // Next state.
  always_comb begin
    tick        = ctl.run && (ctl.cnt_sel ? cnt_fall : pclk_tick);
    trig        = ctl.trig_en && trig_fall;
    count_nxt   = count_r;
    capture_nxt = capture_r;
    phase_nxt   = phase_r;
    ovf_nxt     = 1'b0;
    if (load) begin
      count_nxt = load_val;
    end else begin
      case (ctl.mode)
        mmtc_pkg::MMTC_ET_RELOAD: begin
          if (trig) begin
            count_nxt = reload;
          end else if (tick) begin
            ovf_nxt   = (count_r == mmtc_pkg::WORD_MAX);
            count_nxt = ovf_nxt ? reload : count_r + mmtc_pkg::WORD_ONE;
          end
        end
        mmtc_pkg::MMTC_ET_CAPTURE: begin
          if (trig) begin
            capture_nxt = count_r;
          end
          if (tick) begin
            ovf_nxt   = (count_r == mmtc_pkg::WORD_MAX);
            count_nxt = count_r + mmtc_pkg::WORD_ONE;
          end
        end
        // halved-rate PWM
        // Stepping every second tick doubles the period, to 131072 ticks with a reload of 0.
        mmtc_pkg::MMTC_ET_PWM: begin
          if (tick) begin
            phase_nxt = ~phase_r;
            if (phase_r) begin
              ovf_nxt   = (count_r == mmtc_pkg::WORD_MAX);
              count_nxt = ovf_nxt ? reload : count_r + mmtc_pkg::WORD_ONE;
            end
          end
        end
        default: begin
          count_nxt = count_r;
        end
      endcase
    end
    if (!ctl.tog_en) begin
      pin_nxt = mmtc_pkg::PIN_IDLE;
    end else if (ctl.mode == mmtc_pkg::MMTC_ET_PWM) begin
      pin_nxt = (count_nxt < duty);
    end else begin
      pin_nxt = ovf_nxt ? ~pin_r : pin_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_r   <= mmtc_pkg::WORD_ZERO;
      capture_r <= mmtc_pkg::WORD_ZERO;
      phase_r   <= 1'b0;
      ovf_r     <= 1'b0;
      pin_r     <= mmtc_pkg::PIN_IDLE;
    end else begin
      count_r   <= count_nxt;
      capture_r <= capture_nxt;
      phase_r   <= phase_nxt;
      ovf_r     <= ovf_nxt;
      pin_r     <= pin_nxt;
    end
  end

  // ========================================================================
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_ET_RELOAD: assert property (
    (ctl.mode == mmtc_pkg::MMTC_ET_RELOAD && trig && !load) |=> count_r == $past(reload))
    else $error("Trigger did not reload the count.");

  AST_ET_CAPTURE: assert property (
    (ctl.mode == mmtc_pkg::MMTC_ET_CAPTURE && trig && !load)
      |=> capture_r == $past(count_r))
    else $error("Trigger did not capture the count.");

  AST_ET_TOGGLE: assert property (
    (ovf_r && $past(ctl.tog_en) && $past(ctl.mode) != mmtc_pkg::MMTC_ET_PWM)
      |-> pin_r != $past(pin_r))
    else $error("Overflow did not toggle the pin.");

  AST_ET_IDLE: assert property (
    !ctl.tog_en |=> pin_r)
    else $error("Pin not high with toggling off.");

endmodule

//--- hdl/mmtc_top.sv
// ==========================================================================
// Five timer/counters: two legacy timers and three 16-bit trigger timers.
// Assumes synchronous pin inputs and control held by a CPU-side register
// file outside this block; loads and flag clears arrive as one-clock pulses.
`timescale 1ns/1ns

// Function
// - Timers 0/1 count every machine cycle
// - Timers 2-4 count every peripheral tick, mode 2 every second tick
// - Counter mode counts sampled falling pin edges
// - Timers 0/1 have modes 0,1,2,3,6
// - Mode 0: 8-bit counter, divide-by-32 prescaler
// - Mode 1: full 16-bit counter
// - Mode 2: 8-bit counter with auto-reload
// - Timer 0 mode 3 splits into two
// - Timer 1 mode 3 halts, baud kept only with timer 0 split
// - Mode 6: PWM with 256-tick period
// - Timers 0/1 toggle count pin on overflow
// - Toggle pin stays high before overflow
// - Timers 2-4 toggle count pin on overflow
// - Trigger pin falling edge reloads or captures
// - Timers 2-4 have modes 0,1,2
// - Mode 0: 16-bit auto-reload, trigger reload
// - Mode 1: 16-bit count, trigger capture
// - Mode 2: 16-bit PWM, long period
module mmtc_top (
  input  logic                   clk,
  input  logic                   resetn,
  input  mmtc_pkg::mmtc_lt_ctl_t lt_ctl       [2],
  input  logic [1:0]             lt_load,
  input  logic [15:0]            lt_load_val  [2],
  input  mmtc_pkg::mmtc_et_ctl_t et_ctl       [3],
  input  logic [2:0]             et_load,
  input  logic [15:0]            et_load_val  [3],
  input  logic [15:0]            et_reload    [3],
  input  logic [15:0]            et_duty      [3],
  input  logic [4:0]             count_pin_in,
  input  logic [2:0]             external_trigger_pin,
  input  logic [4:0]             flag_clr,
  input  logic [4:0]             irq_en,
  output logic [4:0]             count_pin_out_r,
  output logic [4:0]             count_pin_oe_n_r,
  output logic [15:0]            lt_count_r   [2],
  output logic [15:0]            et_count_r   [3],
  output logic [15:0]            et_capture_r [3],
  output logic [4:0]             ovf_flag_r,
  output logic                   irq_r,
  output logic                   baud_tick_r
);

  logic        div_r;
  logic        div_nxt;
  logic        mc_tick;
  logic [7:0]  fall;
  logic [15:0] cnt_nxt  [2];
  logic [1:0]  pin_nxt;
  logic [1:0]  lt_ovf;
  logic [1:0]  lt_tick;
  logic        hi_ovf;
  logic        hi_tick;
  logic [7:0]  tl;
  logic [7:0]  th;
  logic [2:0]  et_ovf;
  logic [2:0]  et_pin;
  logic [4:0]  flag_nxt;
  logic [4:0]  oe_n_nxt;
  logic        irq_nxt;
  logic        baud_nxt;

  // ========================================================================
  // Machine cycle divider.
  // machine cycle tick
  // The peripheral clock shares this tick, which saves a second divider.
  always_comb begin
    mc_tick = (div_r == mmtc_pkg::MC_LAST);
    div_nxt = mc_tick ? mmtc_pkg::MC_FIRST : ~div_r;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= mmtc_pkg::MC_FIRST;
    end else begin
      div_r <= div_nxt;
    end
  end

  // ========================================================================
  // Pin edge detection.
  // one-cycle level hold
  // A pulse shorter than a machine cycle may fall between samples and be lost.
  mmtc_fall_det #(
    .W (mmtc_pkg::N_FALL)
  ) u_fall (
    .clk       (clk),
    .resetn    (resetn),
    .sample_en (mc_tick),
    .pin       ({external_trigger_pin, count_pin_in}),
    .fall_r    (fall)
  );

  // ========================================================================
  // Timers 2, 3 and 4.
  genvar g;
  generate
    for (g = 0; g < mmtc_pkg::N_ET; g++) begin : g_et
      mmtc_ext_timer u_et (
        .clk       (clk),
        .resetn    (resetn),
        .ctl       (et_ctl[g]),
        .pclk_tick (mc_tick),
        .cnt_fall  (fall[g + mmtc_pkg::ET_BASE]),
        .trig_fall (fall[g + mmtc_pkg::N_PIN]),
        .load      (et_load[g]),
        .load_val  (et_load_val[g]),
        .reload    (et_reload[g]),
        .duty      (et_duty[g]),
        .count_r   (et_count_r[g]),
        .capture_r (et_capture_r[g]),
        .ovf_r     (et_ovf[g]),
        .pin_r     (et_pin[g])
      );
    end
  endgenerate

  // ========================================================================
  // Timers 0 and 1: next count, overflow and pin level.
  always_comb begin
    // split high half runs on timer 1's run control
    hi_tick = lt_ctl[1].run && mc_tick;
    hi_ovf  = 1'b0;
    tl      = 8'h00;
    th      = 8'h00;
    for (int i = 0; i < mmtc_pkg::N_LT; i++) begin
      lt_tick[i] = lt_ctl[i].run && (lt_ctl[i].cnt_sel ? fall[i] : mc_tick);
      lt_ovf[i]  = 1'b0;
      cnt_nxt[i] = lt_count_r[i];
      tl         = lt_count_r[i][7:0];
      th         = lt_count_r[i][15:8];
      if (lt_load[i]) begin
        cnt_nxt[i] = lt_load_val[i];
      end else begin
        case (lt_ctl[i].mode)
          mmtc_pkg::MMTC_LT_M13: begin
            if (lt_tick[i]) begin
              if (tl[4:0] == mmtc_pkg::PRE_MAX) begin
                cnt_nxt[i][4:0]  = mmtc_pkg::PRE_ZERO;
                cnt_nxt[i][15:8] = th + mmtc_pkg::BYTE_ONE;
                lt_ovf[i]        = (th == mmtc_pkg::BYTE_MAX);
              end else begin
                cnt_nxt[i][4:0] = tl[4:0] + 5'h01;
              end
            end
          end
          mmtc_pkg::MMTC_LT_M16: begin
            if (lt_tick[i]) begin
              cnt_nxt[i] = lt_count_r[i] + mmtc_pkg::WORD_ONE;
              lt_ovf[i]  = (lt_count_r[i] == mmtc_pkg::WORD_MAX);
            end
          end
          mmtc_pkg::MMTC_LT_M8AR: begin
            if (lt_tick[i]) begin
              lt_ovf[i]       = (tl == mmtc_pkg::BYTE_MAX);
              cnt_nxt[i][7:0] = lt_ovf[i] ? th : tl + mmtc_pkg::BYTE_ONE;
            end
          end
          mmtc_pkg::MMTC_LT_SPLIT: begin
            if (i == 0) begin
              if (lt_tick[i]) begin
                cnt_nxt[i][7:0] = tl + mmtc_pkg::BYTE_ONE;
                lt_ovf[i]       = (tl == mmtc_pkg::BYTE_MAX);
              end
              if (hi_tick) begin
                cnt_nxt[i][15:8] = th + mmtc_pkg::BYTE_ONE;
                hi_ovf           = (th == mmtc_pkg::BYTE_MAX);
              end
            end
          end
          mmtc_pkg::MMTC_LT_PWM: begin
            if (lt_tick[i]) begin
              cnt_nxt[i][7:0] = tl + mmtc_pkg::BYTE_ONE;
              lt_ovf[i]       = (tl == mmtc_pkg::BYTE_MAX);
            end
          end
          default: begin
            cnt_nxt[i] = lt_count_r[i];
          end
        endcase
      end
      if (!lt_ctl[i].tog_en) begin
        pin_nxt[i] = mmtc_pkg::PIN_IDLE;
      end else if (lt_ctl[i].mode == mmtc_pkg::MMTC_LT_PWM) begin
        pin_nxt[i] = (cnt_nxt[i][7:0] < cnt_nxt[i][15:8]);
      end else begin
        pin_nxt[i] = lt_ovf[i] ? ~count_pin_out_r[i] : count_pin_out_r[i];
      end
    end
  end

  // ========================================================================
  // Flags, interrupt, baud tick and pin drive.
  always_comb begin
    flag_nxt = (ovf_flag_r & ~flag_clr) | {et_ovf, lt_ovf[1] | hi_ovf, lt_ovf[0]};
    irq_nxt  = |(flag_nxt & irq_en);
    // baud path kept
    // With timer 1 halted the split high half keeps the baud source alive.
    if (lt_ctl[1].mode == mmtc_pkg::MMTC_LT_SPLIT) begin
      baud_nxt = hi_ovf;
    end else begin
      baud_nxt = lt_ovf[1];
    end
    // Two loops keep every control index inside its own array.
    for (int i = 0; i < mmtc_pkg::N_LT; i++) begin
      oe_n_nxt[i] = ~lt_ctl[i].tog_en;
    end
    for (int j = 0; j < mmtc_pkg::N_ET; j++) begin
      oe_n_nxt[j + mmtc_pkg::ET_BASE] = ~et_ctl[j].tog_en;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lt_count_r[0]    <= mmtc_pkg::WORD_ZERO;
      lt_count_r[1]    <= mmtc_pkg::WORD_ZERO;
      count_pin_out_r  <= '1;
      count_pin_oe_n_r <= '1;
      ovf_flag_r       <= '0;
      irq_r            <= 1'b0;
      baud_tick_r      <= 1'b0;
    end else begin
      lt_count_r[0]    <= cnt_nxt[0];
      lt_count_r[1]    <= cnt_nxt[1];
      count_pin_out_r  <= {et_pin, pin_nxt};
      count_pin_oe_n_r <= oe_n_nxt;
      ovf_flag_r       <= flag_nxt;
      irq_r            <= irq_nxt;
      baud_tick_r      <= baud_nxt;
    end
  end

  // ========================================================================
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_MC_RATE: assert property (
    (lt_ctl[0].run && !lt_ctl[0].cnt_sel && lt_ctl[0].mode == mmtc_pkg::MMTC_LT_M16
      && !lt_load[0])[*3] |-> lt_count_r[0] != $past(lt_count_r[0], 2))
    else $error("Timer 0 did not advance within a machine cycle.");

  AST_CNT_EDGE: assert property (
    (fall[0] && lt_ctl[0].run && lt_ctl[0].cnt_sel && !lt_load[0]
      && lt_ctl[0].mode == mmtc_pkg::MMTC_LT_M16)
      |=> lt_count_r[0] == $past(lt_count_r[0]) + mmtc_pkg::WORD_ONE)
    else $error("Counter did not advance on a pin edge.");

  AST_M13_PRE: assert property (
    (lt_tick[0] && !lt_load[0] && lt_ctl[0].mode == mmtc_pkg::MMTC_LT_M13
      && lt_count_r[0][4:0] == mmtc_pkg::PRE_MAX)
      |=> lt_count_r[0][4:0] == mmtc_pkg::PRE_ZERO
        && lt_count_r[0][15:8] == $past(lt_count_r[0][15:8]) + mmtc_pkg::BYTE_ONE)
    else $error("Prescaler wrap did not step the high byte.");

  AST_M8_RELOAD: assert property (
    (lt_tick[0] && !lt_load[0] && lt_ctl[0].mode == mmtc_pkg::MMTC_LT_M8AR
      && lt_count_r[0][7:0] == mmtc_pkg::BYTE_MAX)
      |=> lt_count_r[0][7:0] == $past(lt_count_r[0][15:8]) && ovf_flag_r[0])
    else $error("Auto-reload did not restore the low byte.");

  AST_T1_HALT: assert property (
    (lt_ctl[1].mode == mmtc_pkg::MMTC_LT_SPLIT && !lt_load[1])
      |=> lt_count_r[1] == $past(lt_count_r[1]))
    else $error("Timer 1 counted in mode 3.");

  AST_PIN_IDLE: assert property (
    !lt_ctl[0].tog_en |=> count_pin_out_r[0] && count_pin_oe_n_r[0])
    else $error("Pin not idle high with toggling off.");

  AST_FLAG_SET: assert property (
    et_ovf[0] |=> ovf_flag_r[2] ##1 (irq_r || !$past(irq_en[2]) || $past(flag_clr[2])))
    else $error("Overflow did not set its flag.");

endmodule

//--- tb/mmtc_src_model.sv
// ==========================================================================
// Model of the outside sources that drive the count and trigger pins.
// Assumes the bench resolves each count pin wire against the block's enable.
`timescale 1ns/1ns

module mmtc_src_model (
  input  wire logic       clk,
  output logic      [4:0] cnt_src,
  output logic      [2:0] trig_src
);
  // Pins rest high, as a pulled-up line would between events.
  initial begin
    cnt_src  = 5'h1f;
    trig_src = 3'h7;
  end

  // each level held
  // Two clocks low then two high, so every fall spans a machine cycle.
  task automatic fall_cnt(input int n, input int k);
    repeat (k) begin
      @(negedge clk);
      cnt_src[n] = 1'b0;
      repeat (2) @(negedge clk);
      cnt_src[n] = 1'b1;
      @(negedge clk);
    end
  endtask

  // each level held
  // One trigger fall with the same spacing as the count pins.
  task automatic fall_trig(input int n);
    @(negedge clk);
    trig_src[n] = 1'b0;
    repeat (2) @(negedge clk);
    trig_src[n] = 1'b1;
    @(negedge clk);
  endtask
endmodule

//--- tb/tb.sv
// ==========================================================================
// Self-checking bench for the five timer/counters.
// Assumes the source model drives pins and the bench drives all controls.
`timescale 1ns/1ns

module tb;
  logic                   clk;
  logic                   resetn;
  mmtc_pkg::mmtc_lt_ctl_t lt_ctl       [2];
  logic [1:0]             lt_load;
  logic [15:0]            lt_load_val  [2];
  mmtc_pkg::mmtc_et_ctl_t et_ctl       [3];
  logic [2:0]             et_load;
  logic [15:0]            et_load_val  [3];
  logic [15:0]            et_reload    [3];
  logic [15:0]            et_duty      [3];
  logic [4:0]             pin_in;
  logic [4:0]             cnt_src;
  logic [2:0]             trig_pin;
  logic [4:0]             flag_clr;
  logic [4:0]             irq_en;
  logic [4:0]             pin_out;
  logic [4:0]             pin_oe_n;
  logic [15:0]            lt_count     [2];
  logic [15:0]            et_count     [3];
  logic [15:0]            et_capture   [3];
  logic [4:0]             flags;
  logic                   irq;
  logic                   baud;
  int                     failures;
  int                     total_checks;

  // The wire follows the block where it drives, else the outside source.
  assign pin_in = (pin_oe_n & cnt_src) | (~pin_oe_n & pin_out);

  always #5 clk = ~clk;

  mmtc_top mmtc_top_inst (
    .clk(clk), .resetn(resetn), .lt_ctl(lt_ctl), .lt_load(lt_load),
    .lt_load_val(lt_load_val), .et_ctl(et_ctl), .et_load(et_load),
    .et_load_val(et_load_val), .et_reload(et_reload), .et_duty(et_duty),
    .count_pin_in(pin_in), .external_trigger_pin(trig_pin), .flag_clr(flag_clr),
    .irq_en(irq_en), .count_pin_out_r(pin_out), .count_pin_oe_n_r(pin_oe_n),
    .lt_count_r(lt_count), .et_count_r(et_count), .et_capture_r(et_capture),
    .ovf_flag_r(flags), .irq_r(irq), .baud_tick_r(baud)
  );

  mmtc_src_model mmtc_src_model_inst (.clk(clk), .cnt_src(cnt_src), .trig_src(trig_pin));

  // Shared compare; an unknown bit matches only an unknown in the same bit of exp.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic lt_set(input int i, input logic r, input logic c, input logic t,
                        input mmtc_pkg::mmtc_lt_mode_t m);
    @(negedge clk);
    lt_ctl[i] = '{r, c, t, m};
  endtask

  task automatic et_set(input int i, input logic r, input logic c, input logic t,
                        input logic g, input mmtc_pkg::mmtc_et_mode_t m);
    @(negedge clk);
    et_ctl[i] = '{r, c, t, g, m};
  endtask

  // Loads are one-clock pulses; the value is held across the taking edge.
  task automatic lt_ld(input int i, input logic [15:0] v);
    @(negedge clk);
    lt_load_val[i] = v;
    lt_load[i]     = 1'b1;
    @(negedge clk);
    lt_load[i]     = 1'b0;
  endtask

  task automatic et_ld(input int i, input logic [15:0] v);
    @(negedge clk);
    et_load_val[i] = v;
    et_load[i]     = 1'b1;
    @(negedge clk);
    et_load[i]     = 1'b0;
  endtask

  // Bounded wait for an overflow flag.
  task automatic wait_flag(input int n);
    for (int k = 0; k < 40 && flags[n] !== 1'b1; k++) @(negedge clk);
  endtask

  task automatic stop_all();
    lt_set(0, 1'b0, 1'b0, 1'b0, mmtc_pkg::MMTC_LT_M16);
    lt_set(1, 1'b0, 1'b0, 1'b0, mmtc_pkg::MMTC_LT_M16);
    for (int i = 0; i < 3; i++) et_set(i, 1'b0, 1'b0, 1'b0, 1'b0, mmtc_pkg::MMTC_ET_RELOAD);
  endtask

  // Timer function: one step per machine cycle, i.e. per two clocks.
  task automatic t_rate();
    logic [15:0] a;
    logic [15:0] b;
    lt_set(0, 1'b1, 1'b0, 1'b0, mmtc_pkg::MMTC_LT_M16);
    et_set(0, 1'b1, 1'b0, 1'b0, 1'b0, mmtc_pkg::MMTC_ET_RELOAD);
    tick(2);
    a = lt_count[0];
    b = et_count[0];
    tick(20);
    chk(lt_count[0] - a, 16'h000a);
    chk(et_count[0] - b, 16'h000a);
    stop_all();
    $display("test rate done");
  endtask

  // Mode 0: the high byte steps once per 32 machine cycles.
  task automatic t_m13();
    logic [15:0] a;
    lt_ld(0, 16'h0000);
    lt_set(0, 1'b1, 1'b0, 1'b0, mmtc_pkg::MMTC_LT_M13);
    tick(2);
    a = lt_count[0];
    tick(64);
    chk(lt_count[0][15:8] - a[15:8], 16'h0001);
    chk(lt_count[0][4:0], a[4:0]);
    stop_all();
    $display("test mode0 done");
  endtask

  // Mode 2: low byte reloads from the high byte on wrap.
  task automatic t_m8ar();
    lt_ld(0, 16'hf0fe);
    lt_set(0, 1'b1, 1'b0, 1'b0, mmtc_pkg::MMTC_LT_M8AR);
    wait_flag(0);
    chk(flags[0], 16'h0001);
    chk(lt_count[0][15:8], 16'h00f0);
    chk({15'h0000, lt_count[0][7:1] == 7'h78}, 16'h0001);
    stop_all();
    flag_clr = 5'h1f;
    tick(1);
    flag_clr = 5'h00;
    $display("test mode2 done");
  endtask

  // Overflow: pin high beforehand, then toggled, flag and interrupt set.
  task automatic t_ovf();
    irq_en = 5'h05;
    lt_ld(0, 16'hfffc);
    lt_set(0, 1'b0, 1'b0, 1'b1, mmtc_pkg::MMTC_LT_M16);
    et_reload[0] = 16'h0000;
    et_ld(0, 16'hfffc);
    et_set(0, 1'b0, 1'b0, 1'b1, 1'b0, mmtc_pkg::MMTC_ET_RELOAD);
    tick(2);
    chk({pin_out[2], pin_out[0], pin_oe_n[2], pin_oe_n[0]}, 16'h000c);
    lt_ctl[0].run = 1'b1;
    et_ctl[0].run = 1'b1;
    wait_flag(0);
    wait_flag(2);
    tick(1);
    chk({flags[2], flags[0], irq}, 16'h0007);
    chk({pin_out[2], pin_out[0]}, 16'h0000);
    stop_all();
    flag_clr = 5'h05;
    tick(1);
    flag_clr = 5'h00;
    tick(1);
    chk({flags[2], flags[0], irq}, 16'h0000);
    irq_en = 5'h00;
    $display("test overflow done");
  endtask

  // Counter function: each sampled pin fall adds one.
  task automatic t_cnt();
    logic [15:0] a;
    logic [15:0] b;
    lt_set(0, 1'b1, 1'b1, 1'b0, mmtc_pkg::MMTC_LT_M16);
    et_set(2, 1'b1, 1'b1, 1'b0, 1'b0, mmtc_pkg::MMTC_ET_RELOAD);
    tick(2);
    a = lt_count[0];
    b = et_count[2];
    mmtc_src_model_inst.fall_cnt(0, 5);
    mmtc_src_model_inst.fall_cnt(4, 3);
    tick(4);
    chk(lt_count[0] - a, 16'h0005);
    chk(et_count[2] - b, 16'h0003);
    stop_all();
    $display("test counter done");
  endtask

  // Trigger falls: reload in mode 0, capture in mode 1, timers halted.
  task automatic t_trig();
    et_reload[0] = 16'habcd;
    et_ld(0, 16'h0005);
    et_set(0, 1'b0, 1'b0, 1'b0, 1'b1, mmtc_pkg::MMTC_ET_RELOAD);
    et_ld(1, 16'h1234);
    et_set(1, 1'b0, 1'b0, 1'b0, 1'b1, mmtc_pkg::MMTC_ET_CAPTURE);
    mmtc_src_model_inst.fall_trig(0);
    mmtc_src_model_inst.fall_trig(1);
    tick(4);
    chk(et_count[0], 16'habcd);
    chk(et_capture[1], 16'h1234);
    stop_all();
    $display("test trigger done");
  endtask

  // Mode 6: compare 0x80 gives half of each 256-tick period high.
  task automatic t_pwm();
    int hi;
    hi = 0;
    lt_ld(0, 16'h8000);
    lt_set(0, 1'b1, 1'b0, 1'b1, mmtc_pkg::MMTC_LT_PWM);
    tick(8);
    repeat (512) begin
      @(negedge clk);
      if (pin_out[0] === 1'b1) hi++;
    end
    chk(16'(hi), 16'h0100);
    stop_all();
    $display("test pwm done");
  endtask

  // Mode 3: timer 1 frozen, the timer 0 high half drives the baud tick.
  task automatic t_split();
    lt_ld(0, 16'hfe00);
    lt_ld(1, 16'h1234);
    lt_set(0, 1'b1, 1'b0, 1'b0, mmtc_pkg::MMTC_LT_SPLIT);
    lt_set(1, 1'b1, 1'b0, 1'b0, mmtc_pkg::MMTC_LT_SPLIT);
    for (int k = 0; k < 40 && baud !== 1'b1; k++) @(negedge clk);
    chk({15'h0000, baud}, 16'h0001);
    chk({flags[1], lt_count[0][15:8]}, 16'h0100);
    chk(lt_count[1], 16'h1234);
    stop_all();
    flag_clr = 5'h1f;
    tick(1);
    flag_clr = 5'h00;
    $display("test split done");
  endtask

  // Timer 3 PWM: 16 steps of 4 clocks per period, duty leaves half high.
  task automatic t_epwm();
    int hi;
    hi = 0;
    et_reload[1] = 16'hfff0;
    et_duty[1]   = 16'hfff8;
    et_ld(1, 16'hfff0);
    et_set(1, 1'b1, 1'b0, 1'b1, 1'b0, mmtc_pkg::MMTC_ET_PWM);
    tick(8);
    repeat (64) begin
      @(negedge clk);
      if (pin_out[3] === 1'b1) hi++;
    end
    chk({flags[3], 15'(hi)}, 16'h8020);
    stop_all();
    flag_clr = 5'h1f;
    tick(1);
    flag_clr = 5'h00;
    $display("test ext pwm done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence after a six-cycle reset.
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    failures = 0;
    total_checks = 0;
    lt_load = 2'h0;
    et_load = 3'h0;
    flag_clr = 5'h00;
    irq_en = 5'h00;
    for (int i = 0; i < 2; i++) lt_ctl[i] = '0;
    for (int i = 0; i < 2; i++) lt_load_val[i] = 16'h0000;
    for (int i = 0; i < 3; i++) begin
      et_ctl[i] = '0;
      et_load_val[i] = 16'h0000;
      et_reload[i] = 16'h0000;
      et_duty[i] = 16'h0000;
    end
    tick(6);
    resetn = 1'b1;
    t_rate();
    t_m13();
    t_m8ar();
    t_ovf();
    t_cnt();
    t_trig();
    t_pwm();
    t_split();
    t_epwm();
    test_done();
  end

  // Watchdog well past the fewer than a thousand cycles the tests need.
  initial begin
    #200000;
    failures++;
    test_done();
  end
endmodule
